// *** hw/dtio_defines.svh ***
// timing and reset constants of the dispense trigger block
`ifndef DTIO_DEFINES_SVH
`define DTIO_DEFINES_SVH
`define DTIO_CLK_MHZ        125
`define DTIO_MS_CYCLES      (`DTIO_CLK_MHZ * 1000)
`define DTIO_DEBOUNCE_NS    1000000
`define DTIO_DEBOUNCE_CYC   ((`DTIO_DEBOUNCE_NS * `DTIO_CLK_MHZ + 999) / 1000)
`define DTIO_NUM_RECIPES    6
`define DTIO_RST_REFILL_MS  16'h0002
`define DTIO_RST_DWELL_MS   16'h0008
`define DTIO_RST_DROPS      16'h0001
`endif

// *** hw/dtio_pkg.sv ***
// types of the dispense trigger block
`default_nettype none
package dtio_pkg;
   typedef struct packed
   {
      logic [15:0] refill_ms;
      logic [15:0] dwell_ms;
      logic [15:0] drops;
   } dtio_recipe_t;

   typedef struct packed
   {
      logic [2:0]  idx;
      logic        we;
      dtio_recipe_t data;
   } dtio_store_wr_t;

   typedef struct packed
   {
      logic fluid_low_ok;
      logic fluid_over;
      logic jet_low_ok;
      logic jet_over;
      logic heat_low_ok;
      logic heat_over;
   } dtio_alarm_t;

   typedef enum logic [2:0]
   {
      ST_IDLE   = 3'b001,
      ST_REFILL = 3'b010,
      ST_DWELL  = 3'b100
   } dtio_state_t;
endpackage : dtio_pkg
`default_nettype wire

// *** hw/dtio_input_filter.sv ***
// three-flop synchroniser and debouncer for one pin
`timescale 1ns/1ps
`default_nettype none
`include "dtio_defines.svh"
module dtio_input_filter #(
   parameter int DEBOUNCE_CYC = `DTIO_DEBOUNCE_CYC
) (
   input  wire logic core_clk_i,
   input  wire logic rst_i,
   input  wire logic pin_i,
   output logic      level_o
);
   logic        s1_reg;
   logic        s2_reg;
   logic        s3_reg;
   logic [31:0] cnt_reg;

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
      end
      else
      begin
         s1_reg <= pin_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // level accepted only after it held steady for the whole debounce time
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         cnt_reg <= 32'h0;
         level_o <= 1'b0;
      end
      else if (s2_reg != s3_reg || s3_reg == level_o)
         cnt_reg <= 32'h0;
      else if (cnt_reg >= 32'(DEBOUNCE_CYC - 1))
      begin
         level_o <= s3_reg;
         cnt_reg <= 32'h0;
      end
      else
         cnt_reg <= cnt_reg + 32'h1;
   end
endmodule : dtio_input_filter
`default_nettype wire

// *** hw/dtio_trigger_core.sv ***
// dispense trigger and status interface core
`timescale 1ns/1ps
`default_nettype none
`include "dtio_defines.svh"
// What this block does
// - six separate trigger inputs each belong to one of six stored recipes.
// - asserting trigger n starts recipe n.
// - a started recipe fires its stored drop sequence with its own timing.
// - recipes are held in a store that rst_i does not clear.
// - busy is high for as long as the pump runs a sequence.
// - the stop input aborts a running sequence and stops the pump, and blocks new starts while held.
// - fluid and jet pressure each give a lower-limit-ok and an over-limit output.
// - the heater gives a lower-temperature-ok and an over-temperature output.
// - one trigger dispenses the recipe's drop count of drops in a row.
// - a mode selects whether triggers are read as pulses or as levels.
// - each drop is a refill interval then a dwell interval, both in milliseconds.
module dtio_trigger_core
   import dtio_pkg::*;
#(
   parameter int NUM_RECIPES  = `DTIO_NUM_RECIPES,
   parameter int MS_CYCLES    = `DTIO_MS_CYCLES,
   parameter int DEBOUNCE_CYC = `DTIO_DEBOUNCE_CYC
) (
   input  wire logic                   core_clk_i,
   input  wire logic                   rst_i,
   input  wire logic [NUM_RECIPES-1:0] trig_n_i,
   input  wire logic                   stop_n_i,
   input  wire logic                   level_mode_i,
   input  wire dtio_pkg::dtio_store_wr_t store_wr_i,
   input  wire dtio_pkg::dtio_alarm_t  sensor_i,
   output logic                        busy_o,
   output logic                        jet_open_o,
   output dtio_pkg::dtio_alarm_t       alarm_o,
   output logic [2:0]                  recipe_o
);
   import dtio_pkg::*;

   logic [NUM_RECIPES-1:0] trig_lvl;
   logic [NUM_RECIPES-1:0] trig_prev_reg;
   logic                   stop_lvl;
   logic [NUM_RECIPES-1:0] trig_req;
   dtio_recipe_t           store_reg [NUM_RECIPES];
   dtio_recipe_t           act_reg;
   dtio_state_t            state_reg;
   logic [31:0]            tick_reg;
   logic [15:0]            ms_reg;
   logic [15:0]            drop_reg;
   logic                   ms_tick;
   logic                   stop_req;
   logic                   start;
   logic [2:0]             sel;
   logic                   launch;
   logic                   zero_skip;

   // pins are active low and idle high when undriven, so invert before filtering
   genvar g;
   generate
      for (g = 0; g < NUM_RECIPES; g++)
      begin : g_trig
         logic raw_lvl;
         dtio_input_filter #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_filt (
            .core_clk_i(core_clk_i),
            .rst_i     (rst_i),
            .pin_i     (~trig_n_i[g]),
            .level_o   (raw_lvl)
         );
         assign trig_lvl[g] = raw_lvl;
      end
   endgenerate

   dtio_input_filter #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_stop (
      .core_clk_i(core_clk_i),
      .rst_i     (rst_i),
      .pin_i     (~stop_n_i),
      .level_o   (stop_lvl)
   );
   assign stop_req = stop_lvl;

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
         trig_prev_reg <= '0;
      else
         trig_prev_reg <= trig_lvl;
   end

   // pulse mode fires on the asserting edge, level mode keeps firing while held
   assign trig_req = level_mode_i ? trig_lvl : (trig_lvl & ~trig_prev_reg);

   function automatic logic [2:0] first_set(input logic [NUM_RECIPES-1:0] v);
      logic [2:0] r;
      r = 3'h0;
      for (int i = NUM_RECIPES - 1; i >= 0; i--)
         if (v[i])
            r = 3'(i);
      return r;
   endfunction : first_set

   assign sel   = first_set(trig_req);
   // requests while busy are dropped, not queued
   assign start = (state_reg == ST_IDLE) && (|trig_req) && !stop_req;
   // a recipe with no drops is refused, so it never raises busy
   assign launch = start && (store_reg[sel].drops != 16'h0);

   // recipe store; a flash or battery-backed macro replaces this array in the
   // chip, so contents are not touched by rst_i
   always_ff @(posedge core_clk_i)
   begin
      if (store_wr_i.we && store_wr_i.idx < 3'(NUM_RECIPES))
         store_reg[store_wr_i.idx] <= store_wr_i.data;
   end

   // millisecond timebase, restarted with each interval
   assign ms_tick = (tick_reg == 32'(MS_CYCLES - 1));

   // a zero-length interval ends after one cycle; the next interval must
   // still start from a fresh millisecond
   assign zero_skip = (state_reg == ST_REFILL && act_reg.refill_ms == 16'h0) ||
                      (state_reg == ST_DWELL && act_reg.dwell_ms == 16'h0);

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i || state_reg == ST_IDLE || ms_tick || zero_skip)
         tick_reg <= 32'h0;
      else
         tick_reg <= tick_reg + 32'h1;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         state_reg <= ST_IDLE;
         ms_reg    <= 16'h0;
         drop_reg  <= 16'h0;
      end
      else if (stop_req && state_reg != ST_IDLE)
         state_reg <= ST_IDLE;
      else
      begin
         case (state_reg)
            ST_IDLE:
            begin
               if (launch)
               begin
                  drop_reg  <= store_reg[sel].drops;
                  ms_reg    <= 16'h0;
                  state_reg <= ST_REFILL;
               end
            end
            ST_REFILL:
            begin
               if (ms_tick || act_reg.refill_ms == 16'h0)
               begin
                  if (ms_reg + 16'h1 >= act_reg.refill_ms)
                  begin
                     ms_reg    <= 16'h0;
                     state_reg <= ST_DWELL;
                  end
                  else
                     ms_reg <= ms_reg + 16'h1;
               end
            end
            ST_DWELL:
            begin
               if (ms_tick || act_reg.dwell_ms == 16'h0)
               begin
                  if (ms_reg + 16'h1 >= act_reg.dwell_ms)
                  begin
                     ms_reg <= 16'h0;
                     if (drop_reg <= 16'h1)
                        state_reg <= ST_IDLE;
                     else
                     begin
                        drop_reg  <= drop_reg - 16'h1;
                        state_reg <= ST_REFILL;
                     end
                  end
                  else
                     ms_reg <= ms_reg + 16'h1;
               end
            end
            default:
               state_reg <= ST_IDLE;
         endcase
      end
   end

   // the running recipe is a copy, so a store write during a run cannot
   // change the timing of drops already under way
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         recipe_o <= 3'h0;
         act_reg  <= '{`DTIO_RST_REFILL_MS, `DTIO_RST_DWELL_MS, `DTIO_RST_DROPS};
      end
      else if (launch)
      begin
         act_reg  <= store_reg[sel];
         recipe_o <= sel;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         busy_o     <= 1'b0;
         jet_open_o <= 1'b0;
      end
      else
      begin
         busy_o     <= (state_reg != ST_IDLE);
         jet_open_o <= (state_reg == ST_REFILL);
      end
   end

   // sensor levels are registered so alarm pins glitch-free follow them
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
         alarm_o <= '0;
      else
         alarm_o <= sensor_i;
   end
endmodule : dtio_trigger_core
`default_nettype wire

// *** verif/dtio_host_model.sv ***
// host robot model driving the trigger and stop pins
`timescale 1ns/1ps
`default_nettype none
module dtio_host_model (
   input  wire logic [5:0] press_i,
   input  wire logic       halt_i,
   output logic [5:0]      trig_n_o,
   output logic            stop_n_o
);
   // pins are pulled up, so a released line reads as no request
   assign trig_n_o = ~press_i;
   assign stop_n_o = ~halt_i;
endmodule : dtio_host_model
`default_nettype wire

// *** verif/dtio_monitor.sv ***
// concurrent checks on the dispense trigger ports
`timescale 1ns/1ps
`default_nettype none
module dtio_monitor
   import dtio_pkg::*;
#(
   parameter int NUM_RECIPES = 6
) (
   input wire logic                   core_clk_i,
   input wire logic                   rst_i,
   input wire logic [NUM_RECIPES-1:0] trig_n_i,
   input wire logic                   stop_n_i,
   input wire dtio_pkg::dtio_alarm_t  sensor_i,
   input wire logic                   busy_o,
   input wire logic                   jet_open_o,
   input wire dtio_pkg::dtio_alarm_t  alarm_o,
   input wire logic [2:0]             recipe_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   jet_in_busy_a: assert property (jet_open_o |-> busy_o)
      else $error("jet open while not busy");
   reset_clear_a: assert property (disable iff (1'b0) rst_i |=>
      !busy_o && !jet_open_o && alarm_o == '0 && recipe_o == 3'h0) else $error("reset values");
   alarm_copy_a: assert property (!$past(rst_i) |-> alarm_o == $past(sensor_i))
      else $error("alarm not following sensor");
   stop_abort_a: assert property (!stop_n_i [*8] ##1 !stop_n_i [*6] |->
      !busy_o && !jet_open_o) else $error("stop did not halt pump");
   stop_blocks_a: assert property (!stop_n_i [*8] ##1 !stop_n_i [*6] |->
      $stable(recipe_o)) else $error("start while stopped");
   start_cause_a: assert property ($rose(busy_o) |->
      (($past(trig_n_i, 3) & (NUM_RECIPES'(1) << recipe_o)) == '0) && $past(stop_n_i, 3))
      else $error("start without trigger");
   recipe_hold_a: assert property (busy_o && $past(busy_o) |-> $stable(recipe_o))
      else $error("recipe changed while busy");
   refill_first_a: assert property ($rose(busy_o) |-> jet_open_o)
      else $error("drop does not open with refill");
endmodule : dtio_monitor
`default_nettype wire

// *** verif/testbench.sv ***
// self-checking bench for the dispense trigger block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import dtio_pkg::*;
   localparam int MS = 10;
   logic           core_clk_i = 1'b0;
   logic           rst_i = 1'b1;
   logic [5:0]     press = 6'h00;
   logic           halt = 1'b0;
   logic           lvl = 1'b0;
   dtio_store_wr_t wr = '0;
   dtio_alarm_t    sensor = '0;
   logic [5:0]     trig_n;
   logic           stop_n;
   logic           busy;
   logic           jet;
   dtio_alarm_t    alarm;
   logic [2:0]     recipe;
   int             n_errors = 0;
   int             num_checks = 0;
   int             drops;
   int             jet_cyc;
   int             busy_cyc;
   initial forever #4 core_clk_i = ~core_clk_i;
   dtio_host_model host (.press_i(press), .halt_i(halt), .trig_n_o(trig_n), .stop_n_o(stop_n));
   dtio_trigger_core #(.NUM_RECIPES(6), .MS_CYCLES(MS), .DEBOUNCE_CYC(4)) DUT (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .trig_n_i(trig_n), .stop_n_i(stop_n),
      .level_mode_i(lvl), .store_wr_i(wr), .sensor_i(sensor), .busy_o(busy),
      .jet_open_o(jet), .alarm_o(alarm), .recipe_o(recipe));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask : check
   task automatic test_done;
      $display("checks=%0d errors=%0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done
   task automatic wait_busy(input logic val);
      int k;
      k = 0;
      while (busy !== val)
      begin
         @(negedge core_clk_i);
         k++;
         if (k > 400)
         begin
            n_errors++;
            test_done();
         end
      end
   endtask : wait_busy
   task automatic put(input int idx, input int nd);
      @(negedge core_clk_i);
      wr = '{idx[2:0], 1'b1, '{16'h0001, 16'h0001, nd[15:0]}};
      @(negedge core_clk_i);
      wr.we = 1'b0;
   endtask : put
   // pulse-mode start; counts drops and open cycles until busy drops
   task automatic fire(input int n);
      logic prev;
      int   k;
      drops = 0;
      jet_cyc = 0;
      prev = 1'b0;
      press[n] = 1'b1;
      wait_busy(1'b1);
      press[n] = 1'b0;
      for (k = 0; k < 2000 && busy === 1'b1; k++)
      begin
         if (jet === 1'b1 && prev !== 1'b1)
            drops++;
         if (jet === 1'b1)
            jet_cyc++;
         prev = jet;
         @(negedge core_clk_i);
      end
      busy_cyc = k;
      if (k >= 2000)
      begin
         n_errors++;
         test_done();
      end
      repeat (12) @(negedge core_clk_i);
   endtask : fire
   initial
   begin
      repeat (11) @(negedge core_clk_i);
      check(busy, 0);
      check({jet, recipe, alarm}, 0);
      @(negedge core_clk_i);
      rst_i = 1'b0;
      for (int i = 0; i < 6; i++)
      begin
         sensor = 6'h01 << i;
         repeat (2) @(negedge core_clk_i);
         check(alarm, sensor);
         put(i, i + 1);
      end
      for (int i = 0; i < 6; i++)
      begin
         fire(i);
         check(recipe, i);
         check(drops, i + 1);
         check(jet_cyc, (i + 1) * MS);
         check(busy_cyc, (i + 1) * 2 * MS);
      end
      press[0] = 1'b1;
      wait_busy(1'b1);
      press[1] = 1'b1;
      wait_busy(1'b0);
      press[0] = 1'b0;
      repeat (30) @(negedge core_clk_i);
      check({busy, recipe}, 0);
      press[1] = 1'b0;
      repeat (12) @(negedge core_clk_i);
      lvl = 1'b1;
      press[2] = 1'b1;
      wait_busy(1'b1);
      check(recipe, 2);
      wait_busy(1'b0);
      wait_busy(1'b1);
      press[2] = 1'b0;
      check(recipe, 2);
      wait_busy(1'b0);
      lvl = 1'b0;
      press[5] = 1'b1;
      wait_busy(1'b1);
      press[5] = 1'b0;
      repeat (30) @(negedge core_clk_i);
      halt = 1'b1;
      repeat (15) @(negedge core_clk_i);
      check({busy, jet}, 0);
      press[0] = 1'b1;
      repeat (30) @(negedge core_clk_i);
      check(busy, 0);
      press[0] = 1'b0;
      halt = 1'b0;
      put(4, 0);
      repeat (20) @(negedge core_clk_i);
      press[4] = 1'b1;
      repeat (30) @(negedge core_clk_i);
      check(busy, 0);
      press[4] = 1'b0;
      rst_i = 1'b1;
      repeat (3) @(negedge core_clk_i);
      rst_i = 1'b0;
      fire(1);
      check(drops, 2);
      test_done();
   end
endmodule : testbench
bind dtio_trigger_core dtio_monitor #(.NUM_RECIPES(NUM_RECIPES)) u_mon (
   .core_clk_i(core_clk_i), .rst_i(rst_i), .trig_n_i(trig_n_i), .stop_n_i(stop_n_i),
   .sensor_i(sensor_i), .busy_o(busy_o), .jet_open_o(jet_open_o), .alarm_o(alarm_o),
   .recipe_o(recipe_o));
`default_nettype wire
